/* hdl/timer_set_pkg.sv */
// constants, modes and carrier structs shared by the timer set
package timer_set_pkg;
  // clock rates of the block and of the sampled timing sources
  localparam int unsigned MCLK_HZ = 25_000_000;
  localparam int unsigned LF_HZ = 32_768;
  localparam int unsigned WDT_HZ = 1_500_000;
  localparam logic [22:0] RAT_HZ = 23'h3D0900; // 4 MHz radio time base
  // nominal rtc increment per low-frequency tick, 2^32 / 32768
  localparam logic [31:0] RTC_INC_NOM = 32'h0002_0000;
  // sync bit positions of the foreign clocks
  localparam int SYNC_W = 5;
  localparam int SYNC_LF = 0;
  localparam int SYNC_RAT = 1;
  localparam int SYNC_WDT = 2;
  localparam int SYNC_A24 = 3;
  localparam int SYNC_A2M = 4;
  // counting masks
  localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
  localparam logic [31:0] MASK_32 = 32'hFFFF_FFFF;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00, PWR_IDLE = 2'b01, PWR_STANDBY = 2'b10, PWR_SHUTDOWN = 2'b11
  } pwr_mode_t;
  typedef enum logic [2:0] {
    GPT_ONESHOT = 3'b000, GPT_PERIODIC = 3'b001, GPT_PWM = 3'b010,
    GPT_EDGE_TIME = 3'b011, GPT_EDGE_CNT = 3'b100
  } gpt_mode_t;
  typedef enum logic [1:0] {
    A2_SRC_24M = 2'b00, A2_SRC_2M = 2'b01, A2_SRC_LF = 2'b10
  } aux2_src_t;
  typedef enum logic [1:0] {
    WDT_OFF = 2'b00, WDT_RUN = 2'b01, WDT_WARNED = 2'b10
  } wdt_state_t;

  typedef struct packed {
    logic [31:0] inc;
    logic signed [15:0] cal;
    logic run_in_halt;
    logic [2:0] arm;
    logic [2:0] cap;
    logic [2:0][31:0] cmp;
  } rtc_cfg_t;
  typedef struct packed {
    logic [3:0] wide;
    logic [7:0] en;
    gpt_mode_t [7:0] mode;
    logic [7:0][15:0] load;
    logic [7:0][15:0] match;
  } gpt_cfg_t;
  typedef struct packed {
    logic [1:0] en;
    logic [1:0] periodic;
    logic [1:0] tick_sel;
    logic [1:0][3:0] presc;
    logic [1:0][15:0] load;
  } aux_cfg_t;
  typedef struct packed {
    logic en;
    aux2_src_t src;
    logic [15:0] period;
    logic [3:0] capture;
    logic [3:0] periodic;
    logic [3:0] arm;
    logic [3:0] adc_sel;
    logic [3:0][15:0] cmp;
  } aux2_cfg_t;
  typedef struct packed {
    logic en;
    logic [1:0][31:0] cmp;
  } rat_cfg_t;
  typedef struct packed {
    logic enable;
    logic kick;
    logic irq_ack;
    logic [31:0] reload;
  } wdt_cfg_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic evt;
    logic out;
    logic cap;
    logic stop;
  } gpt_res_t;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1, sync2, sync3;
    logic [69:0] rtc_cnt;
    logic [2:0] rtc_armed, rtc_evt;
    logic [2:0][31:0] rtc_cap;
    logic [7:0][15:0] gpt_cnt, gpt_cap;
    logic [7:0] gpt_done, gpt_in_prev, gpt_evt, gpt_pwm;
    logic [1:0][15:0] aux_pre, aux_cnt;
    logic [1:0] aux_done, aux_tick_prev, aux_evt;
    logic [15:0] a2_cnt;
    logic [3:0] a2_armed, a2_cap_prev, a2_evt, a2_pwm;
    logic a2_adc;
    logic [3:0][15:0] a2_val;
    logic [31:0] rat_cnt, rat_diff;
    logic rat_en_prev;
    logic [1:0] rat_evt;
    wdt_state_t wdt_st;
    logic [31:0] wdt_cnt;
    logic wdt_irq, wdt_rst, wdt_on;
  } state_t;
  localparam state_t STATE_RST = '0;
endpackage

/* hdl/multi_domain_timer_set.sv */
// timer set: rtc, general-purpose, auxiliary, radio and watchdog timers
//
// Contract
// - rtc is 70 bits, three channels, lf clock
// - rtc runs in every mode except shutdown
// - rtc calibration trims rc oscillator drift
// - rtc increment adjustable for other lf rates
// - rtc value readable; dedicated capture channels
// - rtc stops in debug halt by default
// - four timers, each 32-bit or two 16-bit
// - oneshot, periodic, pwm, edge time, edge count
// - timer inputs and outputs go through fabric
// - general timers run in active, idle only
// - aux timers 0,1: 16-bit, power-of-two prescaler
// - aux 0,1 count clocks or tick edges
// - aux 0,1 offer oneshot and periodic modes
// - aux timer 2 from 24M, 2M or lf
// - aux 2 has four oneshot/periodic channels
// - aux 2 drives sensor, adc events, pwm
// - radio timer 32-bit at 4 MHz, multichannel
// - radio timer resynced to rtc on/off
// - watchdog at 1.5 MHz, cannot be stopped
// - watchdog freezes in standby and debug halt
// - unserviced watchdog interrupts then resets
// - lf clock nominally 32.768 kHz
`timescale 1ns/1ps
module multi_domain_timer_set
  import timer_set_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // device state
  input wire pwr_mode_t pwr_mode_i,
  input wire logic dbg_halt_i,
  // foreign timing sources, sampled through three flops
  input wire logic low_freq_system_clock_i,
  input wire logic rat_clk_i,
  input wire logic wdt_clk_i,
  input wire logic aux_24m_clk_i,
  input wire logic aux_2m_clk_i,
  // configuration
  input wire rtc_cfg_t rtc_cfg_i,
  input wire gpt_cfg_t gpt_cfg_i,
  input wire aux_cfg_t aux_cfg_i,
  input wire aux2_cfg_t aux2_cfg_i,
  input wire rat_cfg_t rat_cfg_i,
  input wire wdt_cfg_t wdt_cfg_i,
  // event fabric inputs, same clock
  input wire logic [7:0] gpt_ev_i,
  input wire logic [1:0] aux_tick_i,
  input wire logic [3:0] aux2_cap_i,
  // rtc results
  output logic [69:0] rtc_value_o,
  output logic [2:0] rtc_evt_o,
  output logic [2:0][31:0] rtc_cap_o,
  // general-purpose timer results
  output logic [7:0] gpt_evt_o,
  output logic [7:0] gpt_pwm_o,
  output logic [7:0][15:0] gpt_cap_o,
  // auxiliary timer results
  output logic [1:0] aux_evt_o,
  output logic [1:0][15:0] aux_cnt_o,
  output logic [3:0] aux2_evt_o,
  output logic aux2_adc_trig_o,
  output logic [3:0] aux2_pwm_o,
  output logic [3:0][15:0] aux2_cap_o,
  // radio timer results
  output logic [31:0] rat_time_o,
  output logic [1:0] rat_evt_o,
  // watchdog results
  output logic wdt_active_o,
  output logic wdt_irq_o,
  output logic wdt_rst_o
);
  state_t s_ff, nxt_s;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [SYNC_W-1:0] clk_edge;
  logic rtc_tick, gpt_ok, aux_ok, wdt_tick, wdt_frozen, wdt_expire;
  logic [69:0] rtc_step;
  logic [86:0] rat_prod;
  logic [31:0] rat_conv;

  // one step of a general-purpose counter, 16-bit when mask is MASK_16
  function automatic gpt_res_t gpt_step(input logic [31:0] cnt, input logic [31:0] load,
                                        input logic [31:0] match, input logic [31:0] mask,
                                        input gpt_mode_t mode, input logic edge_in,
                                        input logic run);
    gpt_res_t r;
    r = '{cnt: cnt, evt: 1'b0, out: 1'b0, cap: 1'b0, stop: 1'b0};
    if (run) begin
      if (mode == GPT_EDGE_TIME) begin
        r.cnt = (cnt + 32'h1) & mask;
        r.cap = edge_in;
      end else if ((mode != GPT_EDGE_CNT) || edge_in) begin
        if (cnt == load) begin
          r.evt = 1'b1;
          r.cnt = 32'h0;
          r.stop = (mode == GPT_ONESHOT);
        end else begin
          r.cnt = (cnt + 32'h1) & mask;
        end
      end
      r.out = (mode == GPT_PWM) && (r.cnt < match);
    end
    return r;
  endfunction

  // release the asynchronous reset through two flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // rising edges of the sampled clocks; only the second and third flops are read
  assign clk_edge = s_ff.sync2 & ~s_ff.sync3;
  // rtc advances on lf edges unless off or halted by the debugger
  assign rtc_tick = clk_edge[SYNC_LF] && (pwr_mode_i != PWR_SHUTDOWN) &&
                    !(dbg_halt_i && !rtc_cfg_i.run_in_halt);
  // increment plus signed trim; nominal value is RTC_INC_NOM at 32.768 kHz
  assign rtc_step = {38'h0, rtc_cfg_i.inc} + {{54{rtc_cfg_i.cal[15]}}, rtc_cfg_i.cal};
  assign gpt_ok = (pwr_mode_i == PWR_ACTIVE) || (pwr_mode_i == PWR_IDLE);
  assign aux_ok = (pwr_mode_i != PWR_SHUTDOWN);
  // rtc seconds.fraction scaled to 4 MHz ticks, the radio timer's unit
  assign rat_prod = {23'h0, s_ff.rtc_cnt[63:0]} * {64'h0, RAT_HZ};
  assign rat_conv = rat_prod[63:32];
  assign wdt_tick = clk_edge[SYNC_WDT];
  assign wdt_frozen = (pwr_mode_i == PWR_STANDBY) || dbg_halt_i;
  assign wdt_expire = (s_ff.wdt_st != WDT_OFF) && !wdt_cfg_i.kick && wdt_tick &&
                      !wdt_frozen && (s_ff.wdt_cnt == 32'h0);

  // next-state logic for every timer
  always_comb begin
    logic [15:0] pmask;
    logic a2_tick, a2_wrap, step;
    gpt_res_t r;
    int h;
    nxt_s = s_ff;
    pmask = 16'h0;
    a2_tick = 1'b0;
    a2_wrap = 1'b0;
    step = 1'b0;
    r = '0;
    h = 0;
    // foreign clocks: sync1 feeds only sync2
    nxt_s.sync1 = {aux_2m_clk_i, aux_24m_clk_i, wdt_clk_i, rat_clk_i, low_freq_system_clock_i};
    nxt_s.sync2 = s_ff.sync1;
    nxt_s.sync3 = s_ff.sync2;

    // rtc: 70-bit count, 32-bit fraction; channels compare on 1/65536 s units
    if (rtc_tick) begin
      nxt_s.rtc_cnt = s_ff.rtc_cnt + rtc_step;
    end
    nxt_s.rtc_evt = 3'h0;
    for (int c = 0; c < 3; c++) begin
      if (s_ff.rtc_armed[c] && (s_ff.rtc_cnt[47:16] >= rtc_cfg_i.cmp[c])) begin
        nxt_s.rtc_evt[c] = 1'b1;
        nxt_s.rtc_armed[c] = 1'b0;
      end
      if (rtc_cfg_i.arm[c]) begin
        nxt_s.rtc_armed[c] = 1'b1;
      end
      if (rtc_cfg_i.cap[c]) begin
        nxt_s.rtc_cap[c] = s_ff.rtc_cnt[47:16];
      end
    end

    // general-purpose timers, paired halves form one 32-bit counter
    nxt_s.gpt_in_prev = gpt_ev_i;
    for (int t = 0; t < 4; t++) begin
      if (gpt_cfg_i.wide[t]) begin
        h = 2 * t;
        r = gpt_step({s_ff.gpt_cnt[h+1], s_ff.gpt_cnt[h]},
                     {gpt_cfg_i.load[h+1], gpt_cfg_i.load[h]},
                     {gpt_cfg_i.match[h+1], gpt_cfg_i.match[h]}, MASK_32,
                     gpt_cfg_i.mode[h], gpt_ev_i[h] && !s_ff.gpt_in_prev[h],
                     gpt_cfg_i.en[h] && gpt_ok && !s_ff.gpt_done[h]);
        nxt_s.gpt_cnt[h] = r.cnt[15:0];
        nxt_s.gpt_cnt[h+1] = r.cnt[31:16];
        nxt_s.gpt_evt[h] = r.evt;
        nxt_s.gpt_evt[h+1] = 1'b0;
        nxt_s.gpt_pwm[h] = r.out;
        nxt_s.gpt_pwm[h+1] = 1'b0;
        nxt_s.gpt_done[h] = (s_ff.gpt_done[h] || r.stop) && gpt_cfg_i.en[h];
        nxt_s.gpt_done[h+1] = 1'b0;
        if (r.cap) begin
          nxt_s.gpt_cap[h] = s_ff.gpt_cnt[h];
          nxt_s.gpt_cap[h+1] = s_ff.gpt_cnt[h+1];
        end
      end else begin
        for (int j = 0; j < 2; j++) begin
          h = 2 * t + j;
          r = gpt_step({16'h0, s_ff.gpt_cnt[h]}, {16'h0, gpt_cfg_i.load[h]},
                       {16'h0, gpt_cfg_i.match[h]}, MASK_16, gpt_cfg_i.mode[h],
                       gpt_ev_i[h] && !s_ff.gpt_in_prev[h],
                       gpt_cfg_i.en[h] && gpt_ok && !s_ff.gpt_done[h]);
          nxt_s.gpt_cnt[h] = r.cnt[15:0];
          nxt_s.gpt_evt[h] = r.evt;
          nxt_s.gpt_pwm[h] = r.out;
          nxt_s.gpt_done[h] = (s_ff.gpt_done[h] || r.stop) && gpt_cfg_i.en[h];
          if (r.cap) begin
            nxt_s.gpt_cap[h] = s_ff.gpt_cnt[h];
          end
        end
      end
    end

    // aux timers 0 and 1: prescaler divides clocks or tick edges by 2^N
    nxt_s.aux_tick_prev = aux_tick_i;
    for (int a = 0; a < 2; a++) begin
      nxt_s.aux_evt[a] = 1'b0;
      pmask = (16'h1 << aux_cfg_i.presc[a]) - 16'h1;
      step = aux_cfg_i.tick_sel[a] ? (aux_tick_i[a] && !s_ff.aux_tick_prev[a]) : 1'b1;
      if (!aux_cfg_i.en[a]) begin
        nxt_s.aux_done[a] = 1'b0;
        nxt_s.aux_pre[a] = 16'h0;
        nxt_s.aux_cnt[a] = 16'h0;
      end else if (aux_ok && !s_ff.aux_done[a] && step) begin
        if ((s_ff.aux_pre[a] & pmask) == pmask) begin
          nxt_s.aux_pre[a] = 16'h0;
          if (s_ff.aux_cnt[a] == aux_cfg_i.load[a]) begin
            nxt_s.aux_evt[a] = 1'b1;
            nxt_s.aux_cnt[a] = 16'h0;
            nxt_s.aux_done[a] = !aux_cfg_i.periodic[a];
          end else begin
            nxt_s.aux_cnt[a] = s_ff.aux_cnt[a] + 16'h1;
          end
        end else begin
          nxt_s.aux_pre[a] = s_ff.aux_pre[a] + 16'h1;
        end
      end
    end

    // aux timer 2: source select, period wrap, four capture/compare channels
    case (aux2_cfg_i.src)
      A2_SRC_24M: a2_tick = clk_edge[SYNC_A24];
      A2_SRC_2M: a2_tick = clk_edge[SYNC_A2M];
      A2_SRC_LF: a2_tick = clk_edge[SYNC_LF];
      default: a2_tick = 1'b0;
    endcase
    a2_tick = a2_tick && aux2_cfg_i.en && aux_ok;
    a2_wrap = a2_tick && (s_ff.a2_cnt == aux2_cfg_i.period);
    if (a2_tick) begin
      nxt_s.a2_cnt = a2_wrap ? 16'h0 : s_ff.a2_cnt + 16'h1;
    end
    nxt_s.a2_cap_prev = aux2_cap_i;
    nxt_s.a2_evt = 4'h0;
    for (int c = 0; c < 4; c++) begin
      if (aux2_cfg_i.capture[c]) begin
        step = aux2_cap_i[c] && !s_ff.a2_cap_prev[c];
        if (step && s_ff.a2_armed[c]) begin
          nxt_s.a2_val[c] = s_ff.a2_cnt;
        end
      end else begin
        step = a2_tick && (s_ff.a2_cnt == aux2_cfg_i.cmp[c]);
      end
      step = step && s_ff.a2_armed[c];
      nxt_s.a2_evt[c] = step;
      if (step && !aux2_cfg_i.periodic[c]) begin
        nxt_s.a2_armed[c] = 1'b0;
      end
      if (aux2_cfg_i.arm[c]) begin
        nxt_s.a2_armed[c] = 1'b1;
      end
      // waveform: high from wrap to the channel's compare
      if (a2_wrap) begin
        nxt_s.a2_pwm[c] = 1'b1;
      end else if (step && !aux2_cfg_i.capture[c]) begin
        nxt_s.a2_pwm[c] = 1'b0;
      end
    end
    nxt_s.a2_adc = |(nxt_s.a2_evt & aux2_cfg_i.adc_sel);

    // radio timer: counts 4 MHz edges while on; offset to rtc kept across off time
    nxt_s.rat_en_prev = rat_cfg_i.en;
    nxt_s.rat_evt = 2'h0;
    if (rat_cfg_i.en && !s_ff.rat_en_prev) begin
      nxt_s.rat_cnt = rat_conv + s_ff.rat_diff;
    end else if (!rat_cfg_i.en && s_ff.rat_en_prev) begin
      nxt_s.rat_diff = s_ff.rat_cnt - rat_conv;
    end else if (rat_cfg_i.en && clk_edge[SYNC_RAT]) begin
      nxt_s.rat_cnt = s_ff.rat_cnt + 32'h1;
      for (int c = 0; c < 2; c++) begin
        nxt_s.rat_evt[c] = (nxt_s.rat_cnt == rat_cfg_i.cmp[c]);
      end
    end

    // watchdog: sticky enable, no way to stop; warn first, reset on second expiry
    nxt_s.wdt_rst = 1'b0;
    case (s_ff.wdt_st)
      WDT_OFF: begin
        if (wdt_cfg_i.enable) begin
          nxt_s.wdt_st = WDT_RUN;
          nxt_s.wdt_cnt = wdt_cfg_i.reload;
        end
      end
      WDT_RUN, WDT_WARNED: begin
        if (wdt_cfg_i.kick) begin
          nxt_s.wdt_cnt = wdt_cfg_i.reload;
        end else if (wdt_tick && !wdt_frozen) begin
          nxt_s.wdt_cnt = (s_ff.wdt_cnt == 32'h0) ? wdt_cfg_i.reload : s_ff.wdt_cnt - 32'h1;
        end
        if (wdt_expire && s_ff.wdt_st == WDT_WARNED) begin
          nxt_s.wdt_rst = 1'b1;
          nxt_s.wdt_st = WDT_RUN;
        end else if (wdt_expire) begin
          nxt_s.wdt_st = WDT_WARNED;
        end else if (wdt_cfg_i.irq_ack) begin
          nxt_s.wdt_st = WDT_RUN; // an expiry in the ack cycle wins above
        end
      end
      default: nxt_s.wdt_st = WDT_OFF;
    endcase
    nxt_s.wdt_irq = (nxt_s.wdt_st == WDT_WARNED);
    // registered so the active output needs no decode after the flop
    nxt_s.wdt_on = (nxt_s.wdt_st != WDT_OFF);
  end

  // all timer state in one register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= STATE_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register
  assign rtc_value_o = s_ff.rtc_cnt;
  assign rtc_evt_o = s_ff.rtc_evt;
  assign rtc_cap_o = s_ff.rtc_cap;
  assign gpt_evt_o = s_ff.gpt_evt;
  assign gpt_pwm_o = s_ff.gpt_pwm;
  assign gpt_cap_o = s_ff.gpt_cap;
  assign aux_evt_o = s_ff.aux_evt;
  assign aux_cnt_o = s_ff.aux_cnt;
  assign aux2_evt_o = s_ff.a2_evt;
  assign aux2_adc_trig_o = s_ff.a2_adc;
  assign aux2_pwm_o = s_ff.a2_pwm;
  assign aux2_cap_o = s_ff.a2_val;
  assign rat_time_o = s_ff.rat_cnt;
  assign rat_evt_o = s_ff.rat_evt;
  assign wdt_active_o = s_ff.wdt_on;
  assign wdt_irq_o = s_ff.wdt_irq;
  assign wdt_rst_o = s_ff.wdt_rst;

  // checks on the timers' behaviour
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  property p_rtc_adv;
    rtc_tick |=> rtc_value_o == $past(s_ff.rtc_cnt) + $past(rtc_step);
  endproperty
  a_rtc_adv: assert property (p_rtc_adv) else $error("rtc did not advance by step");
  property p_rtc_off;
    (pwr_mode_i == PWR_SHUTDOWN) |=> $stable(rtc_value_o);
  endproperty
  a_rtc_off: assert property (p_rtc_off) else $error("rtc moved in shutdown");
  property p_rtc_halt;
    (dbg_halt_i && !rtc_cfg_i.run_in_halt) |=> $stable(rtc_value_o);
  endproperty
  a_rtc_halt: assert property (p_rtc_halt) else $error("rtc moved in debug halt");
  property p_gpt_frozen;
    !gpt_ok |=> $stable(s_ff.gpt_cnt) && (gpt_evt_o == 8'h0);
  endproperty
  a_gpt_frozen: assert property (p_gpt_frozen) else $error("timer ran in low power");
  property p_aux_oneshot;
    (nxt_s.aux_evt[1] && !aux_cfg_i.periodic[1] && aux_cfg_i.en[1]) ##1 aux_cfg_i.en[1]
      |=> $stable(aux_cnt_o[1]);
  endproperty
  a_aux_oneshot: assert property (p_aux_oneshot) else $error("oneshot aux kept counting");
  property p_rat_resync;
    $rose(rat_cfg_i.en) |=> rat_time_o == $past(rat_conv) + $past(s_ff.rat_diff);
  endproperty
  a_rat_resync: assert property (p_rat_resync) else $error("radio timer not resynced");
  property p_wdt_sticky;
    wdt_active_o |=> wdt_active_o [*3];
  endproperty
  a_wdt_sticky: assert property (p_wdt_sticky) else $error("watchdog stopped");
  property p_wdt_freeze;
    (wdt_active_o && wdt_frozen && !wdt_cfg_i.kick) |=> $stable(s_ff.wdt_cnt) && !wdt_rst_o;
  endproperty
  a_wdt_freeze: assert property (p_wdt_freeze) else $error("watchdog counted while frozen");
  property p_wdt_warn;
    (wdt_expire && !wdt_irq_o) |=> wdt_irq_o && !wdt_rst_o;
  endproperty
  a_wdt_warn: assert property (p_wdt_warn) else $error("first expiry did not interrupt");
  property p_wdt_reset;
    (wdt_expire && wdt_irq_o) |=> wdt_rst_o ##1 !wdt_rst_o;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("second expiry did not reset");

  c_rtc_evt: cover property (rtc_evt_o != 3'h0);
  c_gpt_wide: cover property (gpt_cfg_i.wide[0] && gpt_evt_o[0]);
  c_aux2_pwm: cover property ($fell(aux2_pwm_o[0]));
  c_wdt_rst: cover property (wdt_rst_o);
endmodule

/* tb/timer_sources.sv */
// partner model: the foreign timing sources that feed the timer set
`timescale 1ns/1ps
module timer_sources (
  // free-running sources
  output logic rat_clk_o,
  output logic wdt_clk_o,
  output logic aux_24m_clk_o,
  output logic aux_2m_clk_o,
  // low-frequency clock, pulsed on request
  output logic low_freq_system_clock_o
);
  initial begin
    rat_clk_o = 1'b0;
    wdt_clk_o = 1'b0;
    aux_24m_clk_o = 1'b0;
    aux_2m_clk_o = 1'b0;
    low_freq_system_clock_o = 1'b0;
  end
  // free-running time bases, unrelated in phase to the system clock
  always #125 rat_clk_o = ~rat_clk_o; // 4 MHz radio base
  always #333.333 wdt_clk_o = ~wdt_clk_o; // 1.5 MHz watchdog base
  always #100 aux_24m_clk_o = ~aux_24m_clk_o; // slow stand-in, 24 MHz unresolvable
  always #250 aux_2m_clk_o = ~aux_2m_clk_o; // 2 MHz source
  // burst of n low-frequency edges; held still between bursts so the
  // bench knows the exact tick count, each level long enough for the sampler
  task automatic lf_burst(input int n);
    for (int i = 0; i < n; i++) begin
      #400 low_freq_system_clock_o = 1'b1; // one lf tick per rise
      #400 low_freq_system_clock_o = 1'b0;
    end
  endtask
endmodule

/* tb/multi_domain_timer_set_tb.sv */
// self-checking testbench for the timer set
`timescale 1ns/1ps
module multi_domain_timer_set_tb;
  import timer_set_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  pwr_mode_t pwr_mode_i = PWR_ACTIVE;
  logic dbg_halt_i = 1'b0;
  logic lf_clk, rat_clk, wdt_clk, a24_clk, a2m_clk;
  rtc_cfg_t rtc_cfg_i = '0;
  gpt_cfg_t gpt_cfg_i = '0;
  aux_cfg_t aux_cfg_i = '0;
  aux2_cfg_t aux2_cfg_i = '0;
  rat_cfg_t rat_cfg_i = '0;
  wdt_cfg_t wdt_cfg_i = '0;
  logic [7:0] gpt_ev_i = 8'h00;
  logic [1:0] aux_tick_i = 2'h0;
  logic [3:0] aux2_cap_i = 4'h0;
  logic [69:0] rtc_value_o;
  logic [2:0] rtc_evt_o;
  logic [2:0][31:0] rtc_cap_o;
  logic [7:0] gpt_evt_o, gpt_pwm_o;
  logic [7:0][15:0] gpt_cap_o;
  logic [1:0] aux_evt_o;
  logic [1:0][15:0] aux_cnt_o;
  logic [3:0] aux2_evt_o, aux2_pwm_o;
  logic aux2_adc_trig_o;
  logic [3:0][15:0] aux2_cap_o;
  logic [31:0] rat_time_o;
  logic [1:0] rat_evt_o;
  logic wdt_active_o, wdt_irq_o, wdt_rst_o;
  int fails = 0;
  int comparisons = 0;
  int hits [10];
  logic [69:0] v0;
  logic [31:0] t0;
  localparam logic [69:0] NOM3 = 70'h60000; // three nominal ticks

  always #20 mclk_i = ~mclk_i;

  timer_sources src (.rat_clk_o(rat_clk), .wdt_clk_o(wdt_clk), .aux_24m_clk_o(a24_clk),
    .aux_2m_clk_o(a2m_clk), .low_freq_system_clock_o(lf_clk));

  multi_domain_timer_set dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .pwr_mode_i(pwr_mode_i),
    .dbg_halt_i(dbg_halt_i), .low_freq_system_clock_i(lf_clk), .rat_clk_i(rat_clk),
    .wdt_clk_i(wdt_clk), .aux_24m_clk_i(a24_clk), .aux_2m_clk_i(a2m_clk),
    .rtc_cfg_i(rtc_cfg_i), .gpt_cfg_i(gpt_cfg_i), .aux_cfg_i(aux_cfg_i),
    .aux2_cfg_i(aux2_cfg_i), .rat_cfg_i(rat_cfg_i), .wdt_cfg_i(wdt_cfg_i),
    .gpt_ev_i(gpt_ev_i), .aux_tick_i(aux_tick_i), .aux2_cap_i(aux2_cap_i),
    .rtc_value_o(rtc_value_o), .rtc_evt_o(rtc_evt_o), .rtc_cap_o(rtc_cap_o),
    .gpt_evt_o(gpt_evt_o), .gpt_pwm_o(gpt_pwm_o), .gpt_cap_o(gpt_cap_o),
    .aux_evt_o(aux_evt_o), .aux_cnt_o(aux_cnt_o), .aux2_evt_o(aux2_evt_o),
    .aux2_adc_trig_o(aux2_adc_trig_o), .aux2_pwm_o(aux2_pwm_o), .aux2_cap_o(aux2_cap_o),
    .rat_time_o(rat_time_o), .rat_evt_o(rat_evt_o), .wdt_active_o(wdt_active_o),
    .wdt_irq_o(wdt_irq_o), .wdt_rst_o(wdt_rst_o));

  // pulse tallies; sampled at the edge, so pre-edge values are seen
  always @(posedge mclk_i) begin
    hits[0] += int'(gpt_evt_o[0] === 1'b1);
    hits[1] += int'(gpt_evt_o[1] === 1'b1);
    hits[2] += int'(aux_evt_o[0] === 1'b1);
    hits[3] += int'(aux_evt_o[1] === 1'b1);
    hits[4] += int'(rtc_evt_o[1] === 1'b1);
    hits[5] += int'(wdt_rst_o === 1'b1);
    hits[6] += int'(gpt_pwm_o[2] === 1'b1);
    hits[7] += int'(aux2_evt_o[0] === 1'b1);
    hits[8] += int'(aux2_adc_trig_o === 1'b1);
    hits[9] += int'(aux2_pwm_o[0] === 1'b1);
  end

  task automatic check(input logic [69:0] seen, input logic [69:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // let n edges pass with fresh tallies; outputs settle 1 ns after the last
  task automatic run(input int n);
    hits = '{default: 0};
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // rtc advance over a burst of three lf ticks in a given state
  task automatic rtc_delta(input pwr_mode_t pm, input logic halt, input logic [69:0] want);
    @(posedge mclk_i);
    pwr_mode_i <= pm;
    dbg_halt_i <= halt;
    run(4);
    v0 = rtc_value_o;
    src.lf_burst(3);
    run(8);
    check(rtc_value_o - v0, want);
  endtask

  // bounded wait for the watchdog interrupt or reset; a hang ends the run
  task automatic wait_high(input bit rst_sel, input int limit);
    int i;
    for (i = 0; i < limit; i++) begin
      @(posedge mclk_i);
      #1;
      if ((rst_sel ? wdt_rst_o : wdt_irq_o) === 1'b1) break;
    end
    if (i == limit) begin
      fails++;
      results();
    end
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    check(rtc_value_o, '0); // rtc clear in reset
    check({wdt_irq_o, gpt_evt_o}, '0); // event outputs clear in reset
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rtc_cfg_i.inc <= RTC_INC_NOM;
    rtc_delta(PWR_ACTIVE, 1'b0, NOM3); // nominal tick increment
    rtc_delta(PWR_STANDBY, 1'b0, NOM3); // rtc alive in standby
    rtc_delta(PWR_SHUTDOWN, 1'b0, '0); // frozen in shutdown
    rtc_delta(PWR_ACTIVE, 1'b1, '0); // halts with the debugger by default
    rtc_cfg_i.run_in_halt <= 1'b1;
    rtc_delta(PWR_ACTIVE, 1'b1, NOM3); // override keeps it running
    rtc_cfg_i.run_in_halt <= 1'b0;
    rtc_cfg_i.inc <= 32'h0003_0000;
    rtc_delta(PWR_ACTIVE, 1'b0, 70'h90000); // adjusted increment
    rtc_cfg_i.inc <= RTC_INC_NOM;
    rtc_cfg_i.cal <= 16'sh0010;
    rtc_delta(PWR_ACTIVE, 1'b0, 70'h60030); // trim added per tick
    // capture and a compare two ticks ahead, armed by one-cycle pulses
    @(posedge mclk_i);
    rtc_cfg_i.cal <= 16'sh0000;
    rtc_cfg_i.cap <= 3'h1;
    rtc_cfg_i.cmp[1] <= rtc_value_o[47:16] + 32'h4;
    rtc_cfg_i.arm <= 3'h2;
    @(posedge mclk_i);
    rtc_cfg_i.cap <= 3'h0;
    rtc_cfg_i.arm <= 3'h0;
    run(3);
    check(rtc_cap_o[0], rtc_value_o[47:16]); // capture channel
    hits[4] = 0;
    src.lf_burst(3);
    // no run here: it would clear the tally taken during the burst
    repeat (8) @(posedge mclk_i);
    check(hits[4], 1); // compare fires once per arm
    // general timers and aux timers side by side
    gpt_cfg_i.mode[0] <= GPT_ONESHOT;
    gpt_cfg_i.mode[1] <= GPT_PERIODIC;
    gpt_cfg_i.mode[2] <= GPT_PWM;
    gpt_cfg_i.load <= {80'h0, 16'h0010, 16'h000A, 16'h000A};
    gpt_cfg_i.match[2] <= 16'h0008;
    gpt_cfg_i.en <= 8'h07;
    aux_cfg_i <= '{en: 2'h3, periodic: 2'h1, tick_sel: 2'h0, presc: '0, load: {2{16'h0005}}};
    run(120);
    check(hits[0], 1); // one-shot stops after one expiry
    check(hits[1] >= 9, 1); // periodic restarts
    check(hits[6] > 0 && hits[6] < 120, 1); // pwm output toggles
    check(hits[2] >= 10, 1); // aux periodic mode
    check(hits[3], 1); // aux one-shot mode
    @(posedge mclk_i);
    pwr_mode_i <= PWR_STANDBY;
    aux_cfg_i.presc[0] <= 4'h2;
    run(1); // skip the event launched while still active
    run(60);
    check(hits[1], 0); // general timers frozen in standby
    @(posedge mclk_i);
    pwr_mode_i <= PWR_IDLE;
    run(120);
    check(hits[1] >= 9, 1); // and run in idle
    check(hits[2] >= 3 && hits[2] <= 6, 1); // divide-by-four prescaler
    // radio timer over 100 cycles of 40 ns at 4 MHz: 16 counts
    @(posedge mclk_i);
    rat_cfg_i.en <= 1'b1; // radio on only with the crystal fast clock
    run(10);
    t0 = rat_time_o;
    run(100);
    check(rat_time_o - t0 >= 32'hE && rat_time_o - t0 <= 32'h12, 1);
    // aux timer 2: three lf ticks, then a capture on channel 1
    @(posedge mclk_i);
    aux2_cfg_i <= '{en: 1'b1, src: A2_SRC_LF, period: 16'h0009, capture: 4'h2,
                    periodic: 4'h1, arm: 4'h3, adc_sel: 4'h1, cmp: {48'h0, 16'h0004}};
    run(4);
    src.lf_burst(3);
    run(8);
    aux2_cap_i <= 4'h2;
    run(3);
    check(aux2_cap_o[1], 16'h0003); // capture holds the lf tick count
    // on 2 MHz: compare at 4, wrap at 9, about 24 ticks
    aux2_cfg_i.src <= A2_SRC_2M;
    run(300);
    check(hits[7] >= 2 && hits[7] <= 3, 1); // periodic compare channel
    check(hits[8], hits[7]); // adc trigger from the selected channel only
    check(hits[9] > 40 && hits[9] < 200, 1); // waveform from wrap to compare
    // watchdog: enable in standby, frozen there and in halt
    @(posedge mclk_i);
    pwr_mode_i <= PWR_STANDBY;
    wdt_cfg_i.reload <= 32'h0000_0003;
    wdt_cfg_i.enable <= 1'b1;
    @(posedge mclk_i);
    wdt_cfg_i.enable <= 1'b0;
    run(200);
    check(wdt_irq_o, 1'b0); // paused in standby
    check(wdt_active_o, 1'b1); // enable cannot be withdrawn
    @(posedge mclk_i);
    pwr_mode_i <= PWR_ACTIVE;
    dbg_halt_i <= 1'b1;
    run(200);
    check(wdt_irq_o, 1'b0); // paused in debug halt
    @(posedge mclk_i);
    dbg_halt_i <= 1'b0;
    wait_high(1'b0, 300); // unserviced expiry interrupts
    wait_high(1'b1, 300); // second unacknowledged expiry resets
    check(wdt_irq_o, 1'b0); // interrupt drops with the reset
    wait_high(1'b0, 300);
    @(posedge mclk_i);
    wdt_cfg_i.irq_ack <= 1'b1;
    @(posedge mclk_i);
    wdt_cfg_i.irq_ack <= 1'b0;
    hits[5] = 0;
    // kicking well inside the 4-tick window keeps it quiet
    repeat (10) begin
      // plain edges keep the reset tally across all ten windows
      repeat (30) @(posedge mclk_i);
      wdt_cfg_i.kick <= 1'b1;
      @(posedge mclk_i);
      wdt_cfg_i.kick <= 1'b0;
    end
    check({hits[5] == 0, wdt_irq_o}, 2'b10); // acked and serviced: no reset
    results();
  end
endmodule
